// file: ctc_down_counter.sv
// Reloading down counter stepped by bit duration ticks
`timescale 1ns/100ps
`default_nettype none
module ctc_down_counter
  import ctc_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             load_in,
  input  wire logic             enable_in,
  input  wire logic             tick_in,
  input  wire logic [WIDTH-1:0] value_in,
  output logic      [WIDTH-1:0] count_out,
  output logic                  expire_out
);
  logic [WIDTH-1:0] count_next;
  logic             expire_next;

  if (WIDTH < 2 || WIDTH > 24)
  begin : g_bad_width
    $error("ctc_down_counter: WIDTH out of range");
  end

  always_comb
  begin
    count_next  = count_out;
    expire_next = 1'b0;
    if (load_in)
      count_next = value_in;
    else if (enable_in && tick_in)
    begin
      // A zero load expires on every tick rather than wrapping
      if (count_out <= WIDTH'(1))
      begin
        expire_next = 1'b1;
        count_next  = value_in;
      end
      else
        count_next = count_out - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_out  <= '0;
      expire_out <= 1'b0;
    end
    else
    begin
      count_out  <= count_next;
      expire_out <= expire_next;
    end
  end
endmodule : ctc_down_counter
`default_nettype wire

// file: ctc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
`default_nettype none
module ctc_pin_sync
  import ctc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic s1_reg, s2_reg, s3_reg;
  logic level_next, rise_next, fall_next;

  always_comb
  begin
    level_next = level_out;
    rise_next  = 1'b0;
    fall_next  = 1'b0;
    // Only the later two stages decide; the first may be metastable
    if (s2_reg == s3_reg && s2_reg != level_out)
    begin
      level_next = s2_reg;
      rise_next  = s2_reg;
      fall_next  = ~s2_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      level_out <= 1'b1;
      rise_out  <= 1'b0;
      fall_out  <= 1'b0;
    end
    else
    begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_out <= level_next;
      rise_out  <= rise_next;
      fall_out  <= fall_next;
    end
  end
endmodule : ctc_pin_sync
`default_nettype wire

// file: ctc_pkg.sv
// Shared constants and types of the card time-out counter unit
`default_nettype none
package ctc_pkg;
  localparam int        ADDR_W          = 5;
  localparam int        DATA_W          = 8;
  // Register offsets
  localparam logic [4:0] TOC_OFS         = 5'h08;
  localparam logic [4:0] RELOAD_LOW_OFS  = 5'h09;
  localparam logic [4:0] RELOAD_MID_OFS  = 5'h0a;
  localparam logic [4:0] RELOAD_HIGH_OFS = 5'h0b;
  localparam logic [4:0] STATUS_OFS      = 5'h0c;
  localparam logic [4:0] IRQ_EN_OFS      = 5'h0d;
  localparam logic [4:0] IRQ_CLR_OFS     = 5'h0e;
  localparam logic [4:0] SESSION_OFS     = 5'h0f;
  localparam logic [4:0] ETU_DIV_OFS     = 5'h10;
  localparam logic [4:0] EXTRA_GUARD_OFS = 5'h11;
  // Mode codes
  localparam logic [7:0] MODE_HALT       = 8'h00;
  localparam logic [7:0] MODE_C1_ONLY    = 8'h05;
  localparam logic [7:0] MODE_WIDE       = 8'h61;
  localparam logic [7:0] MODE_BOTH       = 8'h65;
  // Status, enable and clear layout
  localparam int        STATUS_W        = 4;
  localparam int        ST_C1_BIT       = 0;
  localparam int        ST_WIDE_BIT     = 1;
  localparam int        ST_ATR_MIN_BIT  = 2;
  localparam int        ST_ATR_MAX_BIT  = 3;
  // Session control layout
  localparam int        SES_START_BIT   = 0;
  localparam int        SES_T1_BIT      = 1;
  // Reset values
  localparam logic [7:0] TOC_RESET       = 8'h00;
  localparam logic [7:0] RELOAD_RESET    = 8'h00;
  localparam logic [7:0] ETU_DIV_RESET   = 8'h0f;
  localparam logic [7:0] GUARD_RESET     = 8'h00;
  localparam logic [3:0] STATUS_RESET    = 4'h0;
  localparam logic [1:0] SESSION_RESET   = 2'h0;
  // Answer-to-reset clock windows, in card clock cycles
  localparam int        ATR_CNT_W       = 9;
  localparam logic [8:0] ATR_MIN_CLOCKS  = 9'd200;
  localparam int        ATR_MAX_REV1    = 384;
  localparam int        ATR_MAX_REV2    = 368;
  // Block guard time, in bit duration units
  localparam logic [7:0] BGT_T0_ETU      = 8'h10;
  localparam logic [7:0] BGT_T1_ETU      = 8'h16;
  // Counter 1 sequencing
  typedef enum logic [1:0] {
    C1_IDLE  = 2'b00,
    C1_ARMED = 2'b01,
    C1_RUN   = 2'b10
  } ctc_c1_state_type;
endpackage : ctc_pkg
`default_nettype wire

// file: ctc_timeout_unit.sv
// Card time-out counter unit: registers, counters, ATR windows, guard time
// Behaviour
// - Mode 00 halts all three counters.
// - Mode 05 stops counters 2 and 3; counter 1 keeps auto-reloading.
// - Mode 61 stops counter 1, starts 16-bit high:mid count on write.
// - In 61, 16-bit terminal count sets wide flag and interrupts.
// - Mode 65 starts counter 1 auto-reload on first I/O start bit.
// - Counter 1 terminal count sets its flag, interrupts, restarts.
// - Mode 65 starts 16-bit count on write; expiry flags and interrupts.
// - Session start counts 200 and upper ATR clock windows in hardware.
// - Guard time for T=0 and T=1 timed in dedicated hardware and reported on guard_ok_out.
// - Low reload byte feeds counter 1.
// - Mid reload is low byte, high reload high byte of 16-bit count.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module ctc_timeout_unit
  import ctc_pkg::*;
#(
  parameter int ATR_MAX_CLOCKS = ATR_MAX_REV1
)
(
  input  wire logic              sys_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic              io_line_in,
  input  wire logic              card_clk_in,
  output logic      [DATA_W-1:0] rdata_out,
  output logic                   irq_out,
  output logic                   guard_ok_out
);
  if (ATR_MAX_CLOCKS != ATR_MAX_REV1 && ATR_MAX_CLOCKS != ATR_MAX_REV2)
  begin : g_bad_atr
    $error("ctc_timeout_unit: ATR_MAX_CLOCKS must be 384 or 368");
  end
  localparam logic [8:0] ATR_MAX = 9'(ATR_MAX_CLOCKS);

  function automatic logic wr_hit(input logic [4:0] ofs);
    return wr_in && addr_in == ofs;
  endfunction : wr_hit

  // Reset release
  logic rst_meta_reg, rst_n;
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Pins
  logic io_start, card_rise;
  ctc_pin_sync u_io_sync (
    .clk_in    (sys_clk_in),
    .rst_n_in  (rst_n),
    .pin_in    (io_line_in),
    .level_out (),
    .rise_out  (),
    .fall_out  (io_start)
  );
  ctc_pin_sync u_clk_sync (
    .clk_in    (sys_clk_in),
    .rst_n_in  (rst_n),
    .pin_in    (card_clk_in),
    .level_out (),
    .rise_out  (card_rise),
    .fall_out  ()
  );

  // Software registers
  logic [7:0]          timeout_mode_config_reg, timeout_mode_config_next;
  logic [7:0]          reload_low_byte_reg, reload_low_byte_next;
  logic [7:0]          reload_mid_byte_reg, reload_mid_byte_next;
  logic [7:0]          reload_high_byte_reg, reload_high_byte_next;
  logic [STATUS_W-1:0] irq_en_reg, irq_en_next;
  logic [1:0]          session_reg, session_next;
  logic [7:0]          etu_div_reg, etu_div_next;
  logic [7:0]          extra_guard_reg, extra_guard_next;

  always_comb
  begin
    timeout_mode_config_next = timeout_mode_config_reg;
    reload_low_byte_next     = reload_low_byte_reg;
    reload_mid_byte_next     = reload_mid_byte_reg;
    reload_high_byte_next    = reload_high_byte_reg;
    irq_en_next              = irq_en_reg;
    session_next             = session_reg;
    etu_div_next             = etu_div_reg;
    extra_guard_next         = extra_guard_reg;
    if (wr_hit(TOC_OFS))         timeout_mode_config_next = wdata_in;
    if (wr_hit(RELOAD_LOW_OFS))  reload_low_byte_next     = wdata_in;
    if (wr_hit(RELOAD_MID_OFS))  reload_mid_byte_next     = wdata_in;
    if (wr_hit(RELOAD_HIGH_OFS)) reload_high_byte_next    = wdata_in;
    if (wr_hit(IRQ_EN_OFS))      irq_en_next              = wdata_in[STATUS_W-1:0];
    if (wr_hit(SESSION_OFS))     session_next             = wdata_in[1:0];
    if (wr_hit(ETU_DIV_OFS))     etu_div_next             = wdata_in;
    if (wr_hit(EXTRA_GUARD_OFS)) extra_guard_next         = wdata_in;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timeout_mode_config_reg <= TOC_RESET;
      reload_low_byte_reg     <= RELOAD_RESET;
      reload_mid_byte_reg     <= RELOAD_RESET;
      reload_high_byte_reg    <= RELOAD_RESET;
      irq_en_reg              <= STATUS_RESET;
      session_reg             <= SESSION_RESET;
      etu_div_reg             <= ETU_DIV_RESET;
      extra_guard_reg         <= GUARD_RESET;
    end
    else
    begin
      timeout_mode_config_reg <= timeout_mode_config_next;
      reload_low_byte_reg     <= reload_low_byte_next;
      reload_mid_byte_reg     <= reload_mid_byte_next;
      reload_high_byte_reg    <= reload_high_byte_next;
      irq_en_reg              <= irq_en_next;
      session_reg             <= session_next;
      etu_div_reg             <= etu_div_next;
      extra_guard_reg         <= extra_guard_next;
    end
  end

  // Bit duration unit: one tick every etu_div_reg + 1 system clocks
  logic [7:0] etu_cnt_reg, etu_cnt_next;
  logic       etu_tick_reg, etu_tick_next;
  always_comb
  begin
    etu_tick_next = (etu_cnt_reg >= etu_div_reg);
    etu_cnt_next  = etu_tick_next ? 8'h00 : etu_cnt_reg + 8'h01;
  end

  // Counter sequencing
  ctc_c1_state_type c1_state_reg, c1_state_next;
  logic             wide_run_reg, wide_run_next;
  logic             c1_load, wide_load, c1_expire, wide_expire;
  logic [7:0]       c1_count;
  logic [15:0]      wide_count;

  always_comb
  begin
    c1_state_next = c1_state_reg;
    wide_run_next = wide_run_reg;
    c1_load       = 1'b0;
    wide_load     = 1'b0;
    if (wr_hit(TOC_OFS))
    begin
      // Unlisted codes halt everything, the safest reading of undefined
      unique case (wdata_in)
        MODE_C1_ONLY:
          wide_run_next = 1'b0;
        MODE_WIDE:
        begin
          c1_state_next = C1_IDLE;
          wide_run_next = 1'b1;
          wide_load     = 1'b1;
        end
        MODE_BOTH:
        begin
          c1_state_next = C1_ARMED;
          wide_run_next = 1'b1;
          wide_load     = 1'b1;
        end
        default:
        begin
          c1_state_next = C1_IDLE;
          wide_run_next = 1'b0;
        end
      endcase
    end
    else
    begin
      // One-shot: the wide count stops at its terminal count
      if (wide_expire)
        wide_run_next = 1'b0;
      unique case (c1_state_reg)
        C1_ARMED:
          if (io_start)
          begin
            c1_state_next = C1_RUN;
            c1_load       = 1'b1;
          end
        C1_IDLE, C1_RUN:
          c1_state_next = c1_state_reg;
        default:
          c1_state_next = C1_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c1_state_reg <= C1_IDLE;
      wide_run_reg <= 1'b0;
      etu_cnt_reg  <= 8'h00;
      etu_tick_reg <= 1'b0;
    end
    else
    begin
      c1_state_reg <= c1_state_next;
      wide_run_reg <= wide_run_next;
      etu_cnt_reg  <= etu_cnt_next;
      etu_tick_reg <= etu_tick_next;
    end
  end

  // Counter 1 reloads itself on expiry
  ctc_down_counter #(.WIDTH(8)) u_counter1 (
    .clk_in     (sys_clk_in),
    .rst_n_in   (rst_n),
    .load_in    (c1_load),
    .enable_in  (c1_state_reg == C1_RUN),
    .tick_in    (etu_tick_reg),
    .value_in   (reload_low_byte_reg),
    .count_out  (c1_count),
    .expire_out (c1_expire)
  );
  // Counters 3 and 2 chained
  ctc_down_counter #(.WIDTH(16)) u_counter32 (
    .clk_in     (sys_clk_in),
    .rst_n_in   (rst_n),
    .load_in    (wide_load),
    .enable_in  (wide_run_reg),
    .tick_in    (etu_tick_reg),
    .value_in   ({reload_high_byte_reg, reload_mid_byte_reg}),
    .count_out  (wide_count),
    .expire_out (wide_expire)
  );

  // Answer-to-reset windows on the card clock
  logic [8:0] atr_cnt_reg, atr_cnt_next;
  logic       atr_min_hit, atr_max_hit;
  always_comb
  begin
    atr_cnt_next = atr_cnt_reg;
    atr_min_hit  = 1'b0;
    atr_max_hit  = 1'b0;
    if (!session_reg[SES_START_BIT])
      atr_cnt_next = 9'h000;
    else if (card_rise && atr_cnt_reg != ATR_MAX)
    begin
      atr_cnt_next = atr_cnt_reg + 9'h001;
      atr_min_hit  = (atr_cnt_next == ATR_MIN_CLOCKS);
      atr_max_hit  = (atr_cnt_next == ATR_MAX);
    end
  end

  // Block guard time since the last start bit
  logic [7:0] bgt_cnt_reg, bgt_cnt_next;
  logic       guard_next;
  logic [8:0] guard_need;
  always_comb
  begin
    guard_need   = {1'b0, session_reg[SES_T1_BIT] ? BGT_T1_ETU : BGT_T0_ETU} + {1'b0, extra_guard_reg};
    bgt_cnt_next = bgt_cnt_reg;
    if (io_start)
      bgt_cnt_next = 8'h00;
    else if (etu_tick_reg && bgt_cnt_reg != 8'hff)
      bgt_cnt_next = bgt_cnt_reg + 8'h01;
    guard_next = {1'b0, bgt_cnt_reg} >= guard_need;
  end

  // Status, interrupt and read port
  logic [STATUS_W-1:0] card_link_status_reg, status_next, status_set, status_clr;
  logic [7:0]          rdata_next;
  always_comb
  begin
    status_set = '0;
    status_set[ST_C1_BIT]      = c1_expire;
    status_set[ST_WIDE_BIT]    = wide_expire;
    status_set[ST_ATR_MIN_BIT] = atr_min_hit;
    status_set[ST_ATR_MAX_BIT] = atr_max_hit;
    status_clr = '0;
    if (rd_in && addr_in == STATUS_OFS)
      status_clr = '1;
    if (wr_hit(IRQ_CLR_OFS))
      status_clr = status_clr | wdata_in[STATUS_W-1:0];
    // Set wins so an event in the clearing cycle survives
    status_next = (card_link_status_reg & ~status_clr) | status_set;
    rdata_next  = 8'h00;
    if (rd_in)
    begin
      unique case (addr_in)
        TOC_OFS:         rdata_next = timeout_mode_config_reg;
        STATUS_OFS:      rdata_next = {4'h0, card_link_status_reg};
        IRQ_EN_OFS:      rdata_next = {4'h0, irq_en_reg};
        SESSION_OFS:     rdata_next = {6'h00, session_reg};
        ETU_DIV_OFS:     rdata_next = etu_div_reg;
        EXTRA_GUARD_OFS: rdata_next = extra_guard_reg;
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      atr_cnt_reg          <= 9'h000;
      bgt_cnt_reg          <= 8'h00;
      guard_ok_out         <= 1'b0;
      card_link_status_reg <= STATUS_RESET;
      irq_out              <= 1'b0;
      rdata_out            <= 8'h00;
    end
    else
    begin
      atr_cnt_reg          <= atr_cnt_next;
      bgt_cnt_reg          <= bgt_cnt_next;
      guard_ok_out         <= guard_next;
      card_link_status_reg <= status_next;
      irq_out              <= |(status_next & irq_en_next);
      rdata_out            <= rdata_next;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_mode_wr(logic [7:0] code);
    wr_in && addr_in == TOC_OFS && wdata_in == code;
  endsequence

  halt_all_a: assert property (
    s_mode_wr(MODE_HALT) |=> c1_state_reg == C1_IDLE && !wide_run_reg ##1 !c1_expire && !wide_expire)
    else $error("mode 00 left a counter running");
  keep_c1_a: assert property (
    s_mode_wr(MODE_C1_ONLY) |=> !wide_run_reg && c1_state_reg == $past(c1_state_reg))
    else $error("mode 05 handled counters wrongly");
  wide_start_a: assert property (
    s_mode_wr(MODE_WIDE) |=> wide_run_reg && c1_state_reg == C1_IDLE
      && wide_count == {reload_high_byte_reg, reload_mid_byte_reg})
    else $error("mode 61 did not load the 16-bit count");
  wide_flag_a: assert property (
    wide_expire |=> card_link_status_reg[ST_WIDE_BIT] && !wide_run_reg)
    else $error("16-bit expiry not flagged");
  arm_start_a: assert property (
    c1_state_reg == C1_ARMED && io_start && !wr_in |=> c1_state_reg == C1_RUN
      && c1_count == reload_low_byte_reg)
    else $error("counter 1 did not start on start bit");
  c1_reload_a: assert property (
    c1_expire |-> c1_count == reload_low_byte_reg ##1 card_link_status_reg[ST_C1_BIT])
    else $error("counter 1 expiry not flagged or reloaded");
  both_start_a: assert property (
    s_mode_wr(MODE_BOTH) |=> wide_run_reg && c1_state_reg == C1_ARMED)
    else $error("mode 65 did not arm both counters");
  atr_min_a: assert property (
    session_reg[SES_START_BIT] && card_rise && atr_cnt_reg == ATR_MIN_CLOCKS - 9'h001
      |=> card_link_status_reg[ST_ATR_MIN_BIT])
    else $error("ATR lower window not flagged");
  guard_a: assert property (
    io_start |=> ##1 !guard_ok_out)
    else $error("guard not restarted by start bit");
  etu_step_a: assert property (
    wide_run_reg && !etu_tick_reg && !wide_load && !$past(wide_load) |=> $stable(wide_count))
    else $error("16-bit counter moved without a tick");
  irq_level_a: assert property (
    irq_out == |(card_link_status_reg & irq_en_reg))
    else $error("interrupt does not follow enabled flags");
endmodule : ctc_timeout_unit
`default_nettype wire

// file: ctc_timeout_unit_bench.sv
// Self-checking testbench of the card time-out counter unit
`timescale 1ns/100ps
`default_nettype none
module ctc_timeout_unit_bench
  import ctc_pkg::*;
;
  localparam int ATR_MAX = ATR_MAX_REV1;
  logic              sys_clk_in;
  logic              reset_n_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wdata_in;
  logic              wr_in;
  logic              rd_in;
  logic              io_line_in;
  logic              card_clk_in;
  logic [DATA_W-1:0] rdata_out;
  logic              irq_out;
  logic              guard_ok_out;
  int                n_errors;
  int                n_compared;
  int                n;
  int                ld;
  int                wide;
  logic [7:0]        v;
  logic [7:0]        codes [4];

  ctc_timeout_unit #(.ATR_MAX_CLOCKS(ATR_MAX)) dut_u (
    .sys_clk_in   (sys_clk_in),
    .reset_n_in   (reset_n_in),
    .addr_in      (addr_in),
    .wdata_in     (wdata_in),
    .wr_in        (wr_in),
    .rd_in        (rd_in),
    .io_line_in   (io_line_in),
    .card_clk_in  (card_clk_in),
    .rdata_out    (rdata_out),
    .irq_out      (irq_out),
    .guard_ok_out (guard_ok_out)
  );

  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // Expected cycles for a count of ticks at a given divider
  function automatic int span(input int ticks, input int div);
    return ticks * (div + 1);
  endfunction : span

  function automatic logic [15:0] near(input int seen, input int expv, input int tol);
    return {15'h0000, (seen >= expv - tol) && (seen <= expv + tol)};
  endfunction : near

  task automatic stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    n_compared++;
    if (seen !== expv)
    begin
      $display("wrong value %s expected %h seen %h", what, expv, seen);
      n_errors++;
    end
  endtask : check

  task automatic idle(input int cycles);
    repeat (cycles) @(posedge sys_clk_in);
  endtask : idle

  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    wr_in    <= 1'b0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    rd_in   <= 1'b0;
    #1 d = rdata_out;
  endtask : bus_rd

  task automatic rd_check(input string what, input logic [4:0] a, input logic [7:0] expv);
    logic [7:0] d;
    bus_rd(a, d);
    check(what, {8'h00, d}, {8'h00, expv});
  endtask : rd_check

  // Bounded wait for the interrupt; a timeout ends the run
  task automatic wait_irq(input int limit, output int cycles);
    cycles = 0;
    while (irq_out !== 1'b1)
    begin
      @(posedge sys_clk_in);
      #1 cycles++;
      if (cycles > limit)
      begin
        $display("wrong value irq wait expected 1 seen %b", irq_out);
        n_errors++;
        stop_test();
      end
    end
  endtask : wait_irq

  // Start bit long enough to pass the pin filter
  task automatic start_bit;
    io_line_in <= 1'b0;
    idle(8);
    io_line_in <= 1'b1;
  endtask : start_bit

  task automatic guard_probe(input logic t1, input int at, input logic expv);
    bus_wr(SESSION_OFS, {6'h00, t1, 1'b0});
    idle(200);
    start_bit();
    idle(2);
    #1 check("guard low", {15'h0000, guard_ok_out}, 16'h0000);
    idle(at - 10);
    #1 check("guard time", {15'h0000, guard_ok_out}, {15'h0000, expv});
  endtask : guard_probe

  task automatic card_clocks(input int rises);
    repeat (rises)
    begin
      card_clk_in <= 1'b1;
      idle(4);
      card_clk_in <= 1'b0;
      idle(4);
    end
    idle(8);
  endtask : card_clocks

  initial
  begin
    reset_n_in  = 1'b0;
    addr_in     = '0;
    wdata_in    = '0;
    wr_in       = 1'b0;
    rd_in       = 1'b0;
    io_line_in  = 1'b1;
    card_clk_in = 1'b0;
    n_errors    = 0;
    n_compared  = 0;
    codes       = '{MODE_HALT, MODE_C1_ONLY, MODE_WIDE, MODE_BOTH};
    n = $urandom(32'h0bba);
    idle(8);
    reset_n_in <= 1'b1;
    idle(3);
    check("irq after reset", {15'h0000, irq_out}, 16'h0000);
    rd_check("mode reset", TOC_OFS, TOC_RESET);
    rd_check("status reset", STATUS_OFS, 8'h00);
    rd_check("etu reset", ETU_DIV_OFS, ETU_DIV_RESET);
    rd_check("reload write only", RELOAD_LOW_OFS, 8'h00);
    rd_check("unmapped", 5'h1f, 8'h00);
    foreach (codes[i])
    begin
      bus_wr(TOC_OFS, codes[i]);
      rd_check("mode readback", TOC_OFS, codes[i]);
      bus_wr(TOC_OFS, MODE_HALT);
    end
    v = 8'($urandom_range(255, 0));
    bus_wr(EXTRA_GUARD_OFS, v);
    rd_check("extra guard rw", EXTRA_GUARD_OFS, v);
    bus_wr(EXTRA_GUARD_OFS, 8'h00);
    bus_wr(ETU_DIV_OFS, 8'h01);
    // Drop flags that the mode loop may have left set
    bus_wr(IRQ_CLR_OFS, 8'h0f);
    // 16-bit count from high:mid in mode 61, one shot
    wide = 256 + $urandom_range(64, 16);
    bus_wr(RELOAD_LOW_OFS, 8'h03);
    bus_wr(RELOAD_MID_OFS, 8'(wide));
    bus_wr(RELOAD_HIGH_OFS, 8'h01);
    bus_wr(IRQ_EN_OFS, 8'h03);
    bus_wr(TOC_OFS, MODE_WIDE);
    wait_irq(span(wide, 1) + 20, n);
    check("wide span", near(n, span(wide, 1) + 1, 4), 16'h0001);
    idle(20);
    check("irq held", {15'h0000, irq_out}, 16'h0001);
    rd_check("wide flag", STATUS_OFS, 8'h02);
    idle(1);
    check("irq after read", {15'h0000, irq_out}, 16'h0000);
    idle(span(wide, 1) + 20);
    rd_check("one shot", STATUS_OFS, 8'h00);
    // Halt before expiry leaves nothing set
    bus_wr(TOC_OFS, MODE_HALT);
    bus_wr(TOC_OFS, MODE_WIDE);
    idle(20);
    bus_wr(TOC_OFS, MODE_HALT);
    idle(span(wide, 1) + 20);
    rd_check("halted", STATUS_OFS, 8'h00);
    // Mode 65 wide part starts on the write
    wide = $urandom_range(60, 20);
    bus_wr(RELOAD_MID_OFS, 8'(wide));
    bus_wr(RELOAD_HIGH_OFS, 8'h00);
    bus_wr(IRQ_EN_OFS, 8'h02);
    bus_wr(TOC_OFS, MODE_BOTH);
    wait_irq(span(wide, 1) + 20, n);
    check("wide span 65", near(n, span(wide, 1) + 1, 4), 16'h0001);
    rd_check("wide flag 65", STATUS_OFS, 8'h02);
    bus_wr(TOC_OFS, MODE_HALT);
    // Counter 1 waits for a start bit, then auto-reloads
    ld = $urandom_range(12, 6);
    bus_wr(RELOAD_LOW_OFS, 8'(ld));
    bus_wr(RELOAD_MID_OFS, 8'hff);
    bus_wr(RELOAD_HIGH_OFS, 8'hff);
    bus_wr(IRQ_EN_OFS, 8'h01);
    bus_wr(TOC_OFS, MODE_BOTH);
    idle(span(ld, 1) * 3);
    check("armed only", {15'h0000, irq_out}, 16'h0000);
    start_bit();
    wait_irq(span(ld, 1) + 20, n);
    rd_check("c1 flag", STATUS_OFS, 8'h01);
    wait_irq(span(ld, 1) + 8, n);
    check("c1 period", near(n + 2, span(ld, 1), 1), 16'h0001);
    bus_wr(TOC_OFS, MODE_C1_ONLY);
    rd_check("c1 flag 05", STATUS_OFS, 8'h01);
    wait_irq(span(ld, 1) + 8, n);
    check("c1 keeps running", near(n, span(ld, 1) - 4, 5), 16'h0001);
    bus_wr(TOC_OFS, MODE_HALT);
    // Enable masks the line; clear register drops the flag
    bus_wr(IRQ_EN_OFS, 8'h00);
    idle(1);
    check("masked irq", {15'h0000, irq_out}, 16'h0000);
    rd_check("irq enable rw", IRQ_EN_OFS, 8'h00);
    bus_wr(IRQ_EN_OFS, 8'h01);
    idle(1);
    check("unmasked irq", {15'h0000, irq_out}, 16'h0001);
    bus_wr(IRQ_CLR_OFS, 8'h01);
    idle(1);
    check("cleared irq", {15'h0000, irq_out}, 16'h0000);
    idle(span(ld, 1) * 3);
    rd_check("c1 halted", STATUS_OFS, 8'h00);
    // Guard time with both protocols and extra guard
    bus_wr(ETU_DIV_OFS, 8'h03);
    guard_probe(1'b0, 82, 1'b1);
    guard_probe(1'b1, 82, 1'b0);
    guard_probe(1'b1, 104, 1'b1);
    bus_wr(EXTRA_GUARD_OFS, 8'h08);
    guard_probe(1'b0, 82, 1'b0);
    guard_probe(1'b0, 110, 1'b1);
    // Answer-to-reset windows counted on the card clock
    bus_wr(SESSION_OFS, 8'h01);
    card_clocks(199);
    rd_check("atr before 200", STATUS_OFS, 8'h00);
    card_clocks(1);
    rd_check("atr at 200", STATUS_OFS, 8'h04);
    card_clocks(ATR_MAX - 201);
    rd_check("atr before max", STATUS_OFS, 8'h00);
    card_clocks(1);
    rd_check("atr at max", STATUS_OFS, 8'h08);
    stop_test();
  end
endmodule : ctc_timeout_unit_bench
`default_nettype wire
